// *** logic/sohm_pkg.sv ***
// shared constants, register map and state layout of the overhead monitor registers
package sohm_pkg;

    // ********************************************************************
    // register offsets
    // ********************************************************************
    localparam logic [7:0] MASTER_LOAD_OFS        = 8'h00;
    localparam logic [7:0] LINE_PARITY_LO_OFS     = 8'h1A;
    localparam logic [7:0] LINE_PARITY_HI_OFS     = 8'h1C;
    localparam logic [7:0] LINE_REMOTE_ERR_LO_OFS = 8'h1D;
    localparam logic [7:0] LINE_REMOTE_ERR_MID_OFS = 8'h1E;
    localparam logic [7:0] LINE_REMOTE_ERR_HI_OFS = 8'h1F;
    localparam logic [7:0] LINE_TX_CONTROL_OFS    = 8'h20;
    localparam logic [7:0] LINE_TX_DIAG_OFS       = 8'h21;
    localparam logic [7:0] PATH_ALARM_STATE_OFS   = 8'h30;
    localparam logic [7:0] PATH_EVENT_FLAGS_OFS   = 8'h31;
    localparam logic [7:0] PATH_EVENT_ENABLES_OFS = 8'h33;
    localparam logic [7:0] PATH_LABEL_OFS         = 8'h37;
    localparam logic [7:0] PATH_PARITY_LO_OFS     = 8'h38;
    localparam logic [7:0] PATH_PARITY_HI_OFS     = 8'h39;
    localparam logic [7:0] PATH_FAR_ERR_HI_OFS    = 8'h3B;

    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int POINTER_LOSS_BIT    = 5;
    localparam int PATH_ALARM_IND_BIT  = 3;
    localparam int PATH_REMOTE_BIT     = 2;
    localparam int PATH_PARITY_BIT     = 1;
    localparam int PATH_FAR_ERR_BIT    = 0;
    localparam int LABEL_CHANGE_BIT    = 7;
    localparam int STATUS_RSV_HI_BIT   = 7;
    localparam int STATUS_RSV_LO_BIT   = 0;
    localparam logic [7:0] FLAG_MASK   = 8'hAF;
    localparam logic [2:0] REMOTE_DEFECT_CODE = 3'h6;

    // ********************************************************************
    // counts and timing
    // ********************************************************************
    localparam logic [19:0] LINE_CNT_MAX   = 20'hFFFFF;
    localparam logic [19:0] PATH_CNT_MAX   = 20'h0FFFF;
    localparam logic [1:0]  LABEL_REPEATS  = 2'h3;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          POLL_TIME_NS   = 7000;
    localparam int          POLL_MAX_CYC   = POLL_TIME_NS / CLK_PERIOD_NS;

    // ********************************************************************
    // state of the register block
    // ********************************************************************
    typedef struct packed {
        logic [19:0] line_acc;
        logic [19:0] line_remote_err_count;
        logic [15:0] path_acc;
        logic [15:0] path_parity_err_count;
        logic [6:0]  tx_ctrl;
        logic        line_parity_corrupt;
        logic [1:0]  status_rsv;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [2:0]  alarm_prev;
        logic [7:0]  path_label_value;
        logic [7:0]  cand;
        logic [1:0]  cand_cnt;
        logic [7:0]  rdata;
        logic        irq;
        logic [7:0]  k2_out;
        logic [7:0]  b2_out;
    } sohm_state_type;

    localparam sohm_state_type STATE_RESET = '0;

endpackage : sohm_pkg

// *** logic/sohm_regs.sv ***
// line and path overhead monitor register bank with transmit diagnostics
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

module sohm_regs (
    input  wire logic       REF_CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    output logic      [7:0] REG_RDATA_O,
    input  wire logic       LINE_REMOTE_ERR_I,
    input  wire logic       PATH_PARITY_ERR_I,
    input  wire logic       PATH_FAR_ERR_I,
    input  wire logic       POINTER_LOSS_STATE_I,
    input  wire logic       PATH_ALARM_IND_STATE_I,
    input  wire logic       PATH_REMOTE_DEFECT_STATE_I,
    input  wire logic       LABEL_STROBE_I,
    input  wire logic [7:0] LABEL_BYTE_I,
    input  wire logic [7:0] TX_K2_I,
    input  wire logic [7:0] TX_B2_I,
    output logic      [7:0] TX_K2_O,
    output logic      [7:0] TX_B2_O,
    output logic            INT_O
);

    // ********************************************************************
    // helpers
    // ********************************************************************
    localparam int POLL_BOUND = sohm_pkg::POLL_MAX_CYC;

    // saturating increment shared by both accumulators
    function automatic logic [19:0] sat_inc(input logic [19:0] v,
                                            input logic [19:0] maxv,
                                            input logic        inc);
        logic [19:0] r;
        r = v;
        if (inc && (v != maxv)) begin
            r = v + 20'h00001;
        end
        return r;
    endfunction : sat_inc

    // writes that poll the line counters
    function automatic logic line_poll_addr(input logic [7:0] a);
        return (a >= sohm_pkg::LINE_PARITY_LO_OFS) && (a <= sohm_pkg::LINE_REMOTE_ERR_HI_OFS);
    endfunction : line_poll_addr

    // writes that poll the path counters
    function automatic logic path_poll_addr(input logic [7:0] a);
        return (a >= sohm_pkg::PATH_PARITY_LO_OFS) && (a <= sohm_pkg::PATH_FAR_ERR_HI_OFS);
    endfunction : path_poll_addr

    sohm_pkg::sohm_state_type st_ff;
    sohm_pkg::sohm_state_type nxt_st;
    logic [7:0]               set_vec;
    logic                     line_poll;
    logic                     path_poll;
    logic [2:0]               alarm_now;

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        logic       label_chg;
        logic [7:0] rd_val;
        logic       master;
        logic [19:0] path_inc;
        label_chg = 1'b0;
        rd_val    = 8'h00;
        master    = REG_WR_I && (REG_ADDR_I == sohm_pkg::MASTER_LOAD_OFS);
        path_inc  = sat_inc({4'h0, st_ff.path_acc}, sohm_pkg::PATH_CNT_MAX,
                            PATH_PARITY_ERR_I);
        nxt_st    = st_ff;
        alarm_now = {POINTER_LOSS_STATE_I, PATH_ALARM_IND_STATE_I, PATH_REMOTE_DEFECT_STATE_I};
        line_poll = master || (REG_WR_I && line_poll_addr(REG_ADDR_I));
        path_poll = master || (REG_WR_I && path_poll_addr(REG_ADDR_I));

        // line far-end error accumulator, event beside a poll starts new interval
        if (line_poll) begin
            nxt_st.line_remote_err_count = st_ff.line_acc;
            nxt_st.line_acc = {19'h00000, LINE_REMOTE_ERR_I};
        end else begin
            nxt_st.line_acc = sat_inc(st_ff.line_acc, sohm_pkg::LINE_CNT_MAX,
                                      LINE_REMOTE_ERR_I);
        end

        // path parity accumulator
        if (path_poll) begin
            nxt_st.path_parity_err_count = st_ff.path_acc;
            nxt_st.path_acc = {15'h0000, PATH_PARITY_ERR_I};
        end else begin
            nxt_st.path_acc = path_inc[15:0];
        end

        // label filter: a new byte must repeat in consecutive frames
        if (LABEL_STROBE_I) begin
            if (LABEL_BYTE_I == st_ff.path_label_value) begin
                nxt_st.cand_cnt = 2'h0;
            end else if ((LABEL_BYTE_I == st_ff.cand) && (st_ff.cand_cnt != 2'h0)) begin
                nxt_st.cand_cnt = st_ff.cand_cnt + 2'h1;
                if (st_ff.cand_cnt + 2'h1 == sohm_pkg::LABEL_REPEATS) begin
                    nxt_st.path_label_value = LABEL_BYTE_I;
                    nxt_st.cand_cnt = 2'h0;
                    label_chg = 1'b1;
                end
            end else begin
                nxt_st.cand     = LABEL_BYTE_I;
                nxt_st.cand_cnt = 2'h1;
            end
        end

        // event flags, a new event wins over the read clear
        nxt_st.alarm_prev = alarm_now;
        set_vec = 8'h00;
        set_vec[sohm_pkg::PATH_FAR_ERR_BIT]   = PATH_FAR_ERR_I;
        set_vec[sohm_pkg::PATH_PARITY_BIT]    = PATH_PARITY_ERR_I;
        set_vec[sohm_pkg::PATH_REMOTE_BIT]    = alarm_now[0] ^ st_ff.alarm_prev[0];
        set_vec[sohm_pkg::PATH_ALARM_IND_BIT] = alarm_now[1] ^ st_ff.alarm_prev[1];
        set_vec[sohm_pkg::POINTER_LOSS_BIT]   = alarm_now[2] ^ st_ff.alarm_prev[2];
        set_vec[sohm_pkg::LABEL_CHANGE_BIT]   = label_chg;
        if (REG_RD_I && (REG_ADDR_I == sohm_pkg::PATH_EVENT_FLAGS_OFS)) begin
            nxt_st.flags = set_vec & sohm_pkg::FLAG_MASK;
        end else begin
            nxt_st.flags = (st_ff.flags | set_vec) & sohm_pkg::FLAG_MASK;
        end

        // register writes
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                sohm_pkg::LINE_TX_CONTROL_OFS: begin
                    nxt_st.tx_ctrl = REG_WDATA_I[6:0];
                end
                sohm_pkg::LINE_TX_DIAG_OFS: begin
                    nxt_st.line_parity_corrupt = REG_WDATA_I[0];
                end
                sohm_pkg::PATH_ALARM_STATE_OFS: begin
                    nxt_st.status_rsv = {REG_WDATA_I[sohm_pkg::STATUS_RSV_HI_BIT],
                                         REG_WDATA_I[sohm_pkg::STATUS_RSV_LO_BIT]};
                end
                sohm_pkg::PATH_EVENT_ENABLES_OFS: begin
                    nxt_st.enables = REG_WDATA_I;
                end
                default: begin
                end
            endcase
        end

        // read mux, data shown only in the cycle after the strobe
        case (REG_ADDR_I)
            sohm_pkg::LINE_REMOTE_ERR_LO_OFS: begin
                rd_val = st_ff.line_remote_err_count[7:0];
            end
            sohm_pkg::LINE_REMOTE_ERR_MID_OFS: begin
                rd_val = st_ff.line_remote_err_count[15:8];
            end
            sohm_pkg::LINE_REMOTE_ERR_HI_OFS: begin
                rd_val = {4'h0, st_ff.line_remote_err_count[19:16]};
            end
            sohm_pkg::LINE_TX_CONTROL_OFS: begin
                rd_val = {1'b0, st_ff.tx_ctrl};
            end
            sohm_pkg::LINE_TX_DIAG_OFS: begin
                rd_val = {7'h00, st_ff.line_parity_corrupt};
            end
            sohm_pkg::PATH_ALARM_STATE_OFS: begin
                rd_val = 8'h00;
                rd_val[sohm_pkg::STATUS_RSV_HI_BIT]  = st_ff.status_rsv[1];
                rd_val[sohm_pkg::STATUS_RSV_LO_BIT]  = st_ff.status_rsv[0];
                rd_val[sohm_pkg::POINTER_LOSS_BIT]   = POINTER_LOSS_STATE_I;
                rd_val[sohm_pkg::PATH_ALARM_IND_BIT] = PATH_ALARM_IND_STATE_I;
                rd_val[sohm_pkg::PATH_REMOTE_BIT]    = PATH_REMOTE_DEFECT_STATE_I;
            end
            sohm_pkg::PATH_EVENT_FLAGS_OFS: begin
                rd_val = st_ff.flags;
            end
            sohm_pkg::PATH_EVENT_ENABLES_OFS: begin
                rd_val = st_ff.enables;
            end
            sohm_pkg::PATH_LABEL_OFS: begin
                rd_val = st_ff.path_label_value;
            end
            sohm_pkg::PATH_PARITY_LO_OFS: begin
                rd_val = st_ff.path_parity_err_count[7:0];
            end
            sohm_pkg::PATH_PARITY_HI_OFS: begin
                rd_val = st_ff.path_parity_err_count[15:8];
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
        nxt_st.rdata = REG_RD_I ? rd_val : 8'h00;

        // interrupt follows enabled flags
        nxt_st.irq = |(st_ff.flags & st_ff.enables);

        // transmit overhead corruption and insertion
        nxt_st.k2_out = st_ff.tx_ctrl[0] ? {TX_K2_I[7:3], sohm_pkg::REMOTE_DEFECT_CODE}
                                         : TX_K2_I;
        nxt_st.b2_out = st_ff.line_parity_corrupt ? ~TX_B2_I : TX_B2_I;
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            st_ff <= sohm_pkg::STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign REG_RDATA_O = st_ff.rdata;
    assign TX_K2_O     = st_ff.k2_out;
    assign TX_B2_O     = st_ff.b2_out;
    assign INT_O       = st_ff.irq;

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence s_line_poll;
        line_poll;
    endsequence

    sequence s_path_poll;
        path_poll;
    endsequence

    sequence s_label_run;
        LABEL_STROBE_I && (LABEL_BYTE_I != st_ff.path_label_value);
    endsequence

    sequence s_flags_read;
        REG_RD_I && (REG_ADDR_I == sohm_pkg::PATH_EVENT_FLAGS_OFS);
    endsequence

    AST_LINE_LATCH: assert property (
        s_line_poll |=> st_ff.line_remote_err_count == $past(st_ff.line_acc))
        else $error("line count not latched on poll");

    AST_LINE_RESTART: assert property (
        s_line_poll |-> ##[1:POLL_BOUND] (st_ff.line_acc <= 20'h00001))
        else $error("line counter not restarted");

    AST_MASTER_LOAD: assert property (
        (REG_WR_I && REG_ADDR_I == sohm_pkg::MASTER_LOAD_OFS)
        |=> st_ff.path_parity_err_count == $past(st_ff.path_acc)
            && st_ff.line_remote_err_count == $past(st_ff.line_acc))
        else $error("master load missed an accumulator");

    AST_K2_INSERT: assert property (
        st_ff.tx_ctrl[0] |=> TX_K2_O == {$past(TX_K2_I[7:3]), 3'h6})
        else $error("k2 remote defect code wrong");

    AST_B2_INVERT: assert property (
        st_ff.line_parity_corrupt |=> TX_B2_O == ~$past(TX_B2_I))
        else $error("b2 not inverted");

    AST_STATUS_LIVE: assert property (
        (REG_RD_I && REG_ADDR_I == sohm_pkg::PATH_ALARM_STATE_OFS)
        |=> REG_RDATA_O[5] == $past(POINTER_LOSS_STATE_I)
            && REG_RDATA_O[3] == $past(PATH_ALARM_IND_STATE_I)
            && REG_RDATA_O[2] == $past(PATH_REMOTE_DEFECT_STATE_I))
        else $error("status does not show live alarms");

    AST_PARITY_FLAG: assert property (
        PATH_PARITY_ERR_I |=> st_ff.flags[sohm_pkg::PATH_PARITY_BIT])
        else $error("parity event flag not set");

    AST_FAR_FLAG: assert property (
        PATH_FAR_ERR_I |=> st_ff.flags[sohm_pkg::PATH_FAR_ERR_BIT])
        else $error("far-end event flag not set");

    AST_CHANGE_FLAG: assert property (
        $changed(PATH_ALARM_IND_STATE_I) |=> st_ff.flags[3])
        else $error("alarm change flag not set");

    AST_READ_CLEAR: assert property (
        s_flags_read |=> (st_ff.flags & ~$past(set_vec)) == 8'h00
                         ##1 INT_O == $past(|(st_ff.flags & st_ff.enables)))
        else $error("flags not cleared by read");

    AST_INT_GATE: assert property (
        ##1 INT_O == |($past(st_ff.flags) & $past(st_ff.enables)))
        else $error("interrupt does not follow enabled flags");

    AST_LABEL_FILTER: assert property (
        $changed(st_ff.path_label_value) |-> $past(st_ff.cand_cnt) == 2'h2 && st_ff.flags[7])
        else $error("label accepted without three frames");

    AST_LABEL_RUN: assert property (
        s_label_run ##0 (LABEL_BYTE_I != st_ff.cand) |=> $stable(st_ff.path_label_value))
        else $error("label taken from a broken run");

    AST_PATH_POLL: assert property (
        s_path_poll |=> st_ff.path_parity_err_count == $past(st_ff.path_acc)
                        && st_ff.path_acc == {15'h0000, $past(PATH_PARITY_ERR_I)})
        else $error("path poll lost or kept a count");

    // counters step by one event outside a poll and hold their snapshots
    AST_LINE_COUNT: assert property (
        !line_poll && LINE_REMOTE_ERR_I && (st_ff.line_acc != sohm_pkg::LINE_CNT_MAX)
        |=> st_ff.line_acc == $past(st_ff.line_acc) + 20'h00001)
        else $error("line event not counted");

    AST_PATH_COUNT: assert property (
        !path_poll && PATH_PARITY_ERR_I && ({4'h0, st_ff.path_acc} != sohm_pkg::PATH_CNT_MAX)
        |=> st_ff.path_acc == $past(st_ff.path_acc) + 16'h0001)
        else $error("path event not counted");

    AST_LINE_HOLD: assert property (
        !line_poll |=> $stable(st_ff.line_remote_err_count))
        else $error("line snapshot moved without a poll");

    AST_PATH_HOLD: assert property (
        !path_poll |=> $stable(st_ff.path_parity_err_count))
        else $error("path snapshot moved without a poll");

    // flag, interrupt, label and transmit checks
    AST_REMOTE_FLAG: assert property (
        $changed(PATH_REMOTE_DEFECT_STATE_I) |=> st_ff.flags[sohm_pkg::PATH_REMOTE_BIT])
        else $error("remote change flag not set");

    AST_POINTER_FLAG: assert property (
        $changed(POINTER_LOSS_STATE_I) |=> st_ff.flags[sohm_pkg::POINTER_LOSS_BIT])
        else $error("pointer change flag not set");

    AST_FLAG_HOLD: assert property (
        !(REG_RD_I && (REG_ADDR_I == sohm_pkg::PATH_EVENT_FLAGS_OFS))
        |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
        else $error("flag lost without a read");

    AST_ENABLE_MASK: assert property (
        (st_ff.flags & st_ff.enables) == 8'h00 |=> !INT_O)
        else $error("interrupt without an enabled flag");

    AST_LABEL_HOLD: assert property (
        !LABEL_STROBE_I |=> $stable(st_ff.path_label_value))
        else $error("label moved without a strobe");

    AST_K2_PASS: assert property (
        !st_ff.tx_ctrl[0] |=> TX_K2_O == $past(TX_K2_I))
        else $error("k2 altered while insert is off");

    AST_B2_PASS: assert property (
        !st_ff.line_parity_corrupt |=> TX_B2_O == $past(TX_B2_I))
        else $error("b2 altered while corrupt is off");

endmodule : sohm_regs

// *** tb/sohm_dp_model.sv ***
// behavioural model of the overhead datapath that feeds the register bank
`timescale 1ns/10ps

module sohm_dp_model (
    input  wire logic       clk_i,
    output logic            line_err_o,
    output logic            par_err_o,
    output logic            far_err_o,
    output logic            lop_o,
    output logic            path_alarm_ind_state_o,
    output logic            path_remote_defect_state_o,
    output logic            stb_o,
    output logic      [7:0] byte_o,
    output logic      [7:0] k2_o,
    output logic      [7:0] b2_o
);
    // ********************************************************************
    // idle levels at time zero
    // ********************************************************************
    initial begin
        {line_err_o, par_err_o, far_err_o, lop_o, path_alarm_ind_state_o, path_remote_defect_state_o, stb_o} = '0;
        byte_o = 8'hFF;
        k2_o   = 8'h00;
        b2_o   = 8'h00;
    end

    // events, one per high cycle, sel is {far, parity, line}
    task automatic pulse(input int n, input logic [2:0] sel);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            {far_err_o, par_err_o, line_err_o} <= sel;
        end
        @(posedge clk_i);
        {far_err_o, par_err_o, line_err_o} <= 3'h0;
    endtask : pulse

    // live alarm levels, v is {pointer loss, alarm ind, remote defect}
    task automatic alarms(input logic [2:0] v);
        @(posedge clk_i);
        {lop_o, path_alarm_ind_state_o, path_remote_defect_state_o} <= v;
    endtask : alarms

    // one label byte per frame strobe, byte line garbled between frames
    task automatic label(input logic [7:0] b, input int n);
        repeat (n) begin
            @(posedge clk_i);
            stb_o  <= 1'b1;
            byte_o <= b;
            @(posedge clk_i);
            stb_o  <= 1'b0;
            byte_o <= ~b;
        end
    endtask : label

    // outgoing overhead bytes ahead of the diagnostics
    task automatic tx(input logic [7:0] k2, input logic [7:0] b2);
        @(posedge clk_i);
        k2_o <= k2;
        b2_o <= b2;
    endtask : tx
endmodule : sohm_dp_model

// *** tb/sohm_regs_tb.sv ***
// self-checking bench for the overhead monitor register bank
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module sohm_regs_tb;
    logic       clk, rst, wr_en, rd_en, irq, l_err, p_err, f_err, pointer_loss_state, path_alarm_ind_state, path_remote_defect_state, stb;
    logic [7:0] addr, wdata, rdata, lbl, k2_i, b2_i, k2_o, b2_o;
    int         errors, n_tests;
    localparam logic [7:0] ofs_flags = sohm_pkg::PATH_EVENT_FLAGS_OFS;
    localparam logic [7:0] ofs_en    = sohm_pkg::PATH_EVENT_ENABLES_OFS;
    localparam logic [7:0] ofs_lbl   = sohm_pkg::PATH_LABEL_OFS;
    localparam logic [7:0] ofs_plo   = sohm_pkg::PATH_PARITY_LO_OFS;
    localparam logic [7:0] ofs_phi   = sohm_pkg::PATH_PARITY_HI_OFS;

    // ********************************************************************
    // design, datapath model, clock
    // ********************************************************************
    sohm_regs i_sohm_regs (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_en), .REG_RD_I(rd_en), .REG_RDATA_O(rdata),
        .LINE_REMOTE_ERR_I(l_err), .PATH_PARITY_ERR_I(p_err), .PATH_FAR_ERR_I(f_err),
        .POINTER_LOSS_STATE_I(pointer_loss_state), .PATH_ALARM_IND_STATE_I(path_alarm_ind_state),
        .PATH_REMOTE_DEFECT_STATE_I(path_remote_defect_state), .LABEL_STROBE_I(stb), .LABEL_BYTE_I(lbl),
        .TX_K2_I(k2_i), .TX_B2_I(b2_i), .TX_K2_O(k2_o), .TX_B2_O(b2_o), .INT_O(irq));

    sohm_dp_model i_sohm_dp_model (.clk_i(clk), .line_err_o(l_err), .par_err_o(p_err),
        .far_err_o(f_err), .lop_o(pointer_loss_state), .path_alarm_ind_state_o(path_alarm_ind_state), .path_remote_defect_state_o(path_remote_defect_state), .stb_o(stb),
        .byte_o(lbl), .k2_o(k2_i), .b2_o(b2_i));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ********************************************************************
    // bus cycles
    // ********************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, exp)
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // ********************************************************************
    // scenarios
    // ********************************************************************
    task automatic chk_reset;
        idle(1);
        `CHK(irq, 1'b0)
        rd_chk(ofs_en, 8'h00);
        rd_chk(ofs_lbl, 8'h00);
        rd_chk(8'h05, 8'h00);
    endtask : chk_reset

    // line count above one byte, then master load of both counters
    task automatic line_poll;
        i_sohm_dp_model.pulse(300, 3'b001);
        wr(sohm_pkg::LINE_REMOTE_ERR_LO_OFS, 8'h00);
        rd_chk(sohm_pkg::LINE_REMOTE_ERR_LO_OFS, 8'h2C);
        rd_chk(sohm_pkg::LINE_REMOTE_ERR_MID_OFS, 8'h01);
        rd_chk(sohm_pkg::LINE_REMOTE_ERR_HI_OFS, 8'h00);
        i_sohm_dp_model.pulse(3, 3'b011);
        wr(sohm_pkg::MASTER_LOAD_OFS, 8'h00);
        rd_chk(sohm_pkg::LINE_REMOTE_ERR_LO_OFS, 8'h03);
        rd_chk(sohm_pkg::LINE_REMOTE_ERR_MID_OFS, 8'h00);
        rd_chk(ofs_plo, 8'h03);
    endtask : line_poll

    // path count poll, with one event landing on the poll cycle
    task automatic path_poll;
        logic [7:0] a, b;
        i_sohm_dp_model.pulse(4, 3'b010);
        wr(ofs_phi, 8'h00);
        rd_chk(ofs_plo, 8'h04);
        rd_chk(ofs_phi, 8'h00);
        fork
            wr(sohm_pkg::PATH_FAR_ERR_HI_OFS, 8'h00);
            i_sohm_dp_model.pulse(1, 3'b010);
        join
        rd(ofs_plo, a);
        wr(ofs_plo, 8'h00);
        rd(ofs_plo, b);
        `CHK(8'(a + b), 8'h01)
    endtask : path_poll

    // remote defect code and parity inversion on the transmit bytes
    task automatic tx_diag;
        i_sohm_dp_model.tx(8'hA9, 8'h5A);
        wr(sohm_pkg::LINE_TX_CONTROL_OFS, 8'h01);
        wr(sohm_pkg::LINE_TX_DIAG_OFS, 8'h01);
        idle(2);
        `CHK(k2_o, 8'hAE)
        `CHK(b2_o, 8'hA5)
        rd_chk(sohm_pkg::LINE_TX_CONTROL_OFS, 8'h01);
        wr(sohm_pkg::LINE_TX_CONTROL_OFS, 8'h00);
        wr(sohm_pkg::LINE_TX_DIAG_OFS, 8'h00);
        idle(2);
        `CHK(k2_o, 8'hA9)
        `CHK(b2_o, 8'h5A)
    endtask : tx_diag

    // each flag alone with only its own enable, then a masked change
    task automatic irq_paths;
        logic [7:0] f;
        logic [2:0] al;
        int         bits[6];
        bits = '{0, 1, 2, 3, 5, 7};
        al   = 3'h0;
        rd(ofs_flags, f);
        foreach (bits[i]) begin
            wr(ofs_en, 8'h01 << bits[i]);
            case (bits[i])
                0: i_sohm_dp_model.pulse(1, 3'b100);
                1: i_sohm_dp_model.pulse(1, 3'b010);
                2: al[0] = 1'b1;
                3: al[1] = 1'b1;
                5: al[2] = 1'b1;
                default: i_sohm_dp_model.label(8'h17, 3);
            endcase
            i_sohm_dp_model.alarms(al);
            idle(3);
            `CHK(irq, 1'b1)
            rd_chk(ofs_flags, 8'h01 << bits[i]);
            idle(2);
            `CHK(irq, 1'b0)
        end
        rd_chk(sohm_pkg::PATH_ALARM_STATE_OFS, 8'h2C);
        wr(ofs_en, 8'h00);
        i_sohm_dp_model.alarms(3'h0);
        idle(3);
        `CHK(irq, 1'b0)
        rd_chk(ofs_flags, 8'h2C);
    endtask : irq_paths

    // broken runs of a new label are not accepted
    task automatic label_filter;
        i_sohm_dp_model.label(8'h22, 2);
        i_sohm_dp_model.label(8'h33, 1);
        i_sohm_dp_model.label(8'h22, 2);
        idle(2);
        rd_chk(ofs_lbl, 8'h17);
        i_sohm_dp_model.label(8'h22, 3);
        idle(2);
        rd_chk(ofs_lbl, 8'h22);
        rd_chk(ofs_flags, 8'h80);
    endtask : label_filter

    // ********************************************************************
    // verdict and main sequence
    // ********************************************************************
    task automatic report_and_stop;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop;
    end

    initial begin
        {rst, wr_en, rd_en, addr, wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
        errors  = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_reset;
        line_poll;
        path_poll;
        tx_diag;
        irq_paths;
        label_filter;
        report_and_stop;
    end
endmodule : sohm_regs_tb
